// File: hw/drv_top.sv
// drive run-source selection, ramp control and output polarity
// assumes terminal pins asynchronous to mclk, APB master on mclk
// Summary of operation
// - link off: parameter source, or second terminals
// - link on: command word first or second bits
// - second forward/reverse run; release decelerates
// - forward terminal runs forward; release decelerates
// - reverse terminal runs reverse; release decelerates
// - run functions only on two dedicated terminals
// - time-select off set one, on set two
// - time-select unassigned uses set one
// - forced stop decelerates, then alarm code
// - five outputs assignable, each with polarity
// - outputs reset to normal polarity
// - normal polarity energizes alarm relay on alarm
// - negative polarity de-energizes relay on alarm
// - link-enable unassigned behaves as on
// - codes 87, 88, 89 select switch and runs
`timescale 1ns/1ps
`default_nettype none
module drv_top import drv_pkg::*; (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N_TERM-1:0] term_in,
  output logic transistor_out_one,
  output logic transistor_out_two,
  output logic transistor_out_three,
  output logic relay_out_general,
  output logic alarm_relay_out,
  output logic motor_fwd,
  output logic motor_rev,
  output logic [15:0] motor_speed,
  output logic accel_set_two,
  output logic alarm_active,
  output logic [7:0] alarm_code,
  output logic irq
);
  logic [N_TERM-1:0] term_s;
  logic [2:0] ctrl;
  logic alarm_reset;
  logic [3:0] comm_word;
  logic [N_TERM-1:0][10:0] term_code;
  logic [N_TIME-1:0][15:0] time_val;
  logic [N_OUT-1:0][10:0] out_code;
  logic [31:0] status;
  logic [N_IRQ-1:0] events;
  logic [N_FUNC-1:0][N_TERM-1:0] f_hit, f_on;
  logic [N_FUNC-1:0] f_asg, f_act;
  logic [N_TERM-1:0] t_neg;
  logic [N_TERM-1:0][10:0] t_base;
  logic [N_OUT-1:0] o_nxt;
  drv_state_type state_r, state_nxt;
  logic dir_r, dir_nxt;
  logic [15:0] speed_r, speed_nxt, presc_r, presc_nxt, period;
  logic [N_OUT-1:0] out_r;
  logic fwd_r, rev_r, set_two_r, alarm_r;
  logic [7:0] alarm_code_r;
  // ==========================================================
  // pins and registers
  drv_sync #(.W(N_TERM)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .din(term_in),
    .dout(term_s)
  );

  drv_apb_regs u_regs (
    .mclk(mclk),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ctrl(ctrl),
    .alarm_reset(alarm_reset),
    .comm_word(comm_word),
    .term_code(term_code),
    .time_val(time_val),
    .out_code(out_code),
    .status(status),
    .events(events),
    .irq(irq)
  );
  // ==========================================================
  // terminal function decode
  genvar t, f;
  generate
    for (t = 0; t < N_TERM; t++) begin : g_tdec
      assign t_neg[t] = term_code[t] >= CODE_NEG_OFS;
      assign t_base[t] = t_neg[t] ? term_code[t] - CODE_NEG_OFS
                                  : term_code[t];
      for (f = 0; f < N_FUNC; f++) begin : g_fdec
        // run functions refused outside the dedicated terminals
        if ((f == F_FWD || f == F_REV) && t < RUN_TERM_FIRST) begin : g_no
          assign f_hit[f][t] = 1'b0;
        end else begin : g_yes
          assign f_hit[f][t] = t_base[t] == FUNC_CODE[f];
        end
        assign f_on[f][t] = f_hit[f][t] & (term_s[t] ^ t_neg[t]);
      end
    end
    for (f = 0; f < N_FUNC; f++) begin : g_fred
      assign f_asg[f] = |f_hit[f];
      assign f_act[f] = |f_on[f];
    end
  endgenerate
  // ==========================================================
  // run command source
  wire link_on = f_asg[F_LE] ? f_act[F_LE] : 1'b1;
  wire src_two = f_act[F_FR];
  wire stop_ok = f_asg[F_STOP] ? f_act[F_STOP] : 1'b1;
  wire set_two = f_asg[F_RT] & f_act[F_RT];
  // parameter source: terminal run functions or software bits
  wire par_fwd = ctrl[CTRL_SRC] ? ctrl[CTRL_SW_FWD] : f_act[F_FWD];
  wire par_rev = ctrl[CTRL_SRC] ? ctrl[CTRL_SW_REV] : f_act[F_REV];
  wire loc_fwd = src_two ? f_act[F_SECOND_FORWARD_RUN] : par_fwd;
  wire loc_rev = src_two ? f_act[F_SECOND_REVERSE_RUN] : par_rev;
  wire com_fwd = src_two ? comm_word[COMM_SECOND_FORWARD_RUN] : comm_word[COMM_FWD];
  wire com_rev = src_two ? comm_word[COMM_SECOND_REVERSE_RUN] : comm_word[COMM_REV];
  wire sel_fwd = link_on ? com_fwd : loc_fwd;
  wire sel_rev = link_on ? com_rev : loc_rev;
  wire cmd_fwd = sel_fwd & ~sel_rev;
  wire cmd_rev = sel_rev & ~sel_fwd;
  wire cmd_run = cmd_fwd | cmd_rev;
  wire cmd_dir = cmd_rev;
  // ==========================================================
  // ramp timing
  wire accel = state_r == ST_RUN;
  always_comb begin
    if (state_r == ST_FSTOP)
      period = time_val[T_FSTOP];
    else if (set_two_r)
      period = accel ? time_val[T_ACC2] : time_val[T_DEC2];
    else
      period = accel ? time_val[T_ACC1] : time_val[T_DEC1];
  end
  wire tick = presc_r >= period;
  assign presc_nxt = tick ? 16'h0000 : presc_r + 16'h0001;
  // ==========================================================
  // motor state
  always_comb begin
    state_nxt = state_r;
    dir_nxt = dir_r;
    speed_nxt = speed_r;
    unique case (state_r)
      ST_STOP: begin
        if (!stop_ok) begin
          state_nxt = ST_FSTOP;
        end else if (cmd_run) begin
          state_nxt = ST_RUN;
          dir_nxt = cmd_dir;
        end
      end
      ST_RUN: begin
        if (!stop_ok)
          state_nxt = ST_FSTOP;
        else if (!cmd_run || cmd_dir != dir_r)
          state_nxt = ST_DECEL;
        else if (tick && speed_r < SPEED_MAX)
          speed_nxt = speed_r + 16'h0001;
      end
      ST_DECEL: begin
        if (!stop_ok)
          state_nxt = ST_FSTOP;
        else if (cmd_run && cmd_dir == dir_r)
          state_nxt = ST_RUN;
        else if (speed_r == 16'h0000)
          state_nxt = ST_STOP;
        else if (tick)
          speed_nxt = speed_r - 16'h0001;
      end
      ST_FSTOP: begin
        if (speed_r == 16'h0000)
          state_nxt = ST_ALARM;
        else if (tick)
          speed_nxt = speed_r - 16'h0001;
      end
      ST_ALARM: begin
        if (alarm_reset && stop_ok)
          state_nxt = ST_STOP;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r <= ST_STOP;
      dir_r <= 1'b0;
      speed_r <= 16'h0000;
      presc_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      dir_r <= dir_nxt;
      speed_r <= speed_nxt;
      presc_r <= (state_nxt != state_r) ? 16'h0000 : presc_nxt;
    end
  end
  // ==========================================================
  // events and status
  wire alarm_nxt = state_nxt == ST_ALARM;
  wire running = state_r == ST_RUN || state_r == ST_DECEL
    || state_r == ST_FSTOP;
  assign events[IRQ_ALARM] = alarm_nxt & (state_r != ST_ALARM);
  assign events[IRQ_STOPPED] = (state_nxt == ST_STOP)
    & (state_r == ST_DECEL);
  assign events[IRQ_START] = (state_nxt == ST_RUN) & (state_r == ST_STOP);
  assign status = {alarm_code_r, 3'h0, link_on, set_two_r, alarm_r,
    fwd_r | rev_r, dir_r, speed_r};
  // ==========================================================
  // programmable outputs
  generate
    for (t = 0; t < N_OUT; t++) begin : g_out
      wire o_neg = out_code[t] >= CODE_NEG_OFS;
      wire [10:0] o_base = o_neg ? out_code[t] - CODE_NEG_OFS : out_code[t];
      wire o_sig = (o_base == OUT_FN_ALARM) ? alarm_nxt :
                   (o_base == OUT_FN_RUN) ? (state_nxt != ST_STOP &&
                                             !alarm_nxt) : 1'b0;
      // polarity flips the energized level
      assign o_nxt[t] = o_sig ^ o_neg;
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      // de-energized until reset releases; default codes normal
      out_r <= '0;
      fwd_r <= 1'b0;
      rev_r <= 1'b0;
      set_two_r <= 1'b0;
      alarm_r <= 1'b0;
      alarm_code_r <= 8'h00;
    end else begin
      out_r <= o_nxt;
      fwd_r <= running & ~dir_r;
      rev_r <= running & dir_r;
      set_two_r <= set_two;
      alarm_r <= alarm_nxt;
      if (events[IRQ_ALARM])
        alarm_code_r <= ALARM_CODE_FSTOP;
      else if (!alarm_nxt)
        alarm_code_r <= 8'h00;
    end
  end

  assign transistor_out_one = out_r[0];
  assign transistor_out_two = out_r[1];
  assign transistor_out_three = out_r[2];
  assign relay_out_general = out_r[3];
  assign alarm_relay_out = out_r[4];
  assign motor_fwd = fwd_r;
  assign motor_rev = rev_r;
  assign motor_speed = speed_r;
  assign accel_set_two = set_two_r;
  assign alarm_active = alarm_r;
  assign alarm_code = alarm_code_r;
endmodule
`default_nettype wire

// File: hw/drv_pkg.sv
// constants, register map and types of the drive run-source block
// assumes a 50 MHz mclk and an APB slave at byte addresses below 0x5c
package drv_pkg;
  // ==========================================================
  // sizes
  localparam int N_TERM = 7;
  localparam int N_OUT = 5;
  localparam int N_FUNC = 8;
  localparam int N_TIME = 5;
  localparam int N_IRQ = 3;
  // ==========================================================
  // terminal function codes, negative logic adds the offset
  localparam logic [10:0] CODE_NEG_OFS = 11'h3e8;
  localparam int F_RT = 0;
  localparam int F_LE = 1;
  localparam int F_STOP = 2;
  localparam int F_FR = 3;
  localparam int F_SECOND_FORWARD_RUN = 4;
  localparam int F_SECOND_REVERSE_RUN = 5;
  localparam int F_FWD = 6;
  localparam int F_REV = 7;
  localparam logic [7:0][10:0] FUNC_CODE = {
    11'h063, 11'h062, 11'h059, 11'h058,
    11'h057, 11'h01e, 11'h018, 11'h004};
  // first terminal index that may carry forward/reverse run
  localparam int RUN_TERM_FIRST = 5;
  // ==========================================================
  // output signal codes
  localparam logic [10:0] OUT_FN_RUN = 11'h000;
  localparam logic [10:0] OUT_FN_ALARM = 11'h063;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COMM = 8'h04;
  localparam logic [7:0] ADDR_TERM0 = 8'h08;
  localparam logic [7:0] ADDR_TIME0 = 8'h24;
  localparam logic [7:0] ADDR_OUT0 = 8'h38;
  localparam logic [7:0] ADDR_STAT = 8'h4c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h50;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h54;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h58;
  // ==========================================================
  // field positions
  localparam int CTRL_SRC = 0;
  localparam int CTRL_SW_FWD = 1;
  localparam int CTRL_SW_REV = 2;
  localparam int CTRL_ALM_RST = 3;
  localparam int COMM_FWD = 0;
  localparam int COMM_REV = 1;
  localparam int COMM_SECOND_FORWARD_RUN = 2;
  localparam int COMM_SECOND_REVERSE_RUN = 3;
  localparam int T_ACC1 = 0;
  localparam int T_DEC1 = 1;
  localparam int T_ACC2 = 2;
  localparam int T_DEC2 = 3;
  localparam int T_FSTOP = 4;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_STOPPED = 1;
  localparam int IRQ_START = 2;
  // ==========================================================
  // reset values and speed limit
  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [3:0] RST_COMM = 4'h0;
  localparam logic [10:0] RST_TERM_CODE = 11'h7ff;
  localparam logic [15:0] RST_TIME = 16'h0031;
  localparam logic [10:0] RST_OUT_CODE = 11'h063;
  localparam logic [2:0] RST_IRQ = 3'h0;
  localparam logic [15:0] SPEED_MAX = 16'h03e8;
  // arbitrary value
  localparam logic [7:0] ALARM_CODE_FSTOP = 8'h01;
  // ==========================================================
  typedef enum logic [2:0] {
    ST_STOP, ST_RUN, ST_DECEL, ST_FSTOP, ST_ALARM
  } drv_state_type;
endpackage

// File: hw/drv_sync.sv
// two-flop synchroniser for the terminal pins
// assumes pins are asynchronous to mclk
`timescale 1ns/1ps
`default_nettype none
module drv_sync #(
  parameter int W = 7
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule
`default_nettype wire

// File: hw/drv_apb_regs.sv
// APB register file and interrupt status of the drive block
// assumes an APB master on mclk; answers after one wait state
`timescale 1ns/1ps
`default_nettype none
module drv_apb_regs import drv_pkg::*; (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [2:0] ctrl,
  output logic alarm_reset,
  output logic [3:0] comm_word,
  output logic [N_TERM-1:0][10:0] term_code,
  output logic [N_TIME-1:0][15:0] time_val,
  output logic [N_OUT-1:0][10:0] out_code,
  input wire logic [31:0] status,
  input wire logic [N_IRQ-1:0] events,
  output logic irq
);
  logic [2:0] ctrl_r;
  logic [3:0] comm_r;
  logic [N_TERM-1:0][10:0] term_r;
  logic [N_TIME-1:0][15:0] time_r;
  logic [N_OUT-1:0][10:0] out_r;
  logic [N_IRQ-1:0] irq_stat_r, irq_stat_nxt, irq_en_r;
  logic pready_r, pslverr_r, alarm_reset_r, irq_r;
  logic [31:0] prdata_r;
  logic [N_TERM-1:0] term_hit;
  logic [N_TIME-1:0] time_hit;
  logic [N_OUT-1:0] out_hit;
  logic [31:0] arr_rd;
  // ==========================================================
  // decode
  wire commit = psel & penable & pready_r;
  wire wr = commit & pwrite;
  wire ctrl_hit = paddr == ADDR_CTRL;
  wire comm_hit = paddr == ADDR_COMM;
  wire stat_hit = paddr == ADDR_STAT;
  wire ist_hit = paddr == ADDR_IRQ_STAT;
  wire ien_hit = paddr == ADDR_IRQ_EN;
  wire iclr_hit = paddr == ADDR_IRQ_CLR;
  genvar g;
  generate
    for (g = 0; g < N_TERM; g++) begin : g_term
      assign term_hit[g] = paddr == ADDR_TERM0 + 8'(4 * g);
    end
    for (g = 0; g < N_TIME; g++) begin : g_time
      assign time_hit[g] = paddr == ADDR_TIME0 + 8'(4 * g);
    end
    for (g = 0; g < N_OUT; g++) begin : g_out
      assign out_hit[g] = paddr == ADDR_OUT0 + 8'(4 * g);
    end
  endgenerate
  wire mapped = ctrl_hit | comm_hit | stat_hit | ist_hit | ien_hit
    | iclr_hit | (|term_hit) | (|time_hit) | (|out_hit);

  always_comb begin
    arr_rd = '0;
    for (int i = 0; i < N_TERM; i++)
      if (term_hit[i]) arr_rd = arr_rd | {21'h0, term_r[i]};
    for (int i = 0; i < N_TIME; i++)
      if (time_hit[i]) arr_rd = arr_rd | {16'h0, time_r[i]};
    for (int i = 0; i < N_OUT; i++)
      if (out_hit[i]) arr_rd = arr_rd | {21'h0, out_r[i]};
  end

  wire [31:0] rd_val = ctrl_hit ? {29'h0, ctrl_r} :
    comm_hit ? {28'h0, comm_r} :
    stat_hit ? status :
    ist_hit ? {29'h0, irq_stat_r} :
    ien_hit ? {29'h0, irq_en_r} : arr_rd;
  // set wins over a clear in the same cycle
  wire [N_IRQ-1:0] clr_mask = (wr & iclr_hit) ? pwdata[N_IRQ-1:0] : '0;
  assign irq_stat_nxt = (irq_stat_r & ~clr_mask) | events;
  // ==========================================================
  // bus handshake
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      alarm_reset_r <= 1'b0;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped;
      if (psel & penable & ~pready_r)
        prdata_r <= (mapped & ~pwrite) ? rd_val : '0;
      alarm_reset_r <= wr & ctrl_hit & pwdata[CTRL_ALM_RST];
    end
  end
  // ==========================================================
  // storage
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_r <= RST_CTRL;
      comm_r <= RST_COMM;
      term_r <= {N_TERM{RST_TERM_CODE}};
      time_r <= {N_TIME{RST_TIME}};
      out_r <= {N_OUT{RST_OUT_CODE}};
      irq_en_r <= RST_IRQ;
    end else if (wr) begin
      if (ctrl_hit) ctrl_r <= pwdata[2:0];
      if (comm_hit) comm_r <= pwdata[3:0];
      if (ien_hit) irq_en_r <= pwdata[N_IRQ-1:0];
      for (int i = 0; i < N_TERM; i++)
        if (term_hit[i]) term_r[i] <= pwdata[10:0];
      for (int i = 0; i < N_TIME; i++)
        if (time_hit[i]) time_r[i] <= pwdata[15:0];
      for (int i = 0; i < N_OUT; i++)
        if (out_hit[i]) out_r[i] <= pwdata[10:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_stat_r <= RST_IRQ;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_en_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign ctrl = ctrl_r;
  assign alarm_reset = alarm_reset_r;
  assign comm_word = comm_r;
  assign term_code = term_r;
  assign time_val = time_r;
  assign out_code = out_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// File: testbench/drv_top_properties.sv
// concurrent checks on the ports of drv_top
// assumes one clock mclk and synchronous active-low rst_b
`timescale 1ns/1ps
`default_nettype none
module drv_top_props import drv_pkg::*; (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic motor_fwd,
  input wire logic motor_rev,
  input wire logic [15:0] motor_speed,
  input wire logic alarm_active,
  input wire logic [7:0] alarm_code
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // bus timing
  property p_rdy_pulse; pready |=> !pready; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("pready high two cycles");
  property p_rdy_wait; psel && penable && !pready |=> pready; endproperty
  a_rdy_wait: assert property (p_rdy_wait)
    else $error("pready late");
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc)
    else $error("pready outside access");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy)
    else $error("pslverr without pready");
  // ==========================================================
  // motion and alarm
  property p_dir_excl; !(motor_fwd && motor_rev); endproperty
  a_dir_excl: assert property (p_dir_excl)
    else $error("both directions");
  property p_ramp;
    (motor_speed == $past(motor_speed)) ||
    (motor_speed == $past(motor_speed) + 16'h1) ||
    (motor_speed == $past(motor_speed) - 16'h1);
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("speed jumped");
  property p_spd_dir; motor_speed != 16'h0 |-> motor_fwd || motor_rev;
  endproperty
  a_spd_dir: assert property (p_spd_dir)
    else $error("speed without direction");
  property p_spd_max; motor_speed <= SPEED_MAX; endproperty
  a_spd_max: assert property (p_spd_max)
    else $error("speed above max");
  property p_alm_code; alarm_active |-> alarm_code == ALARM_CODE_FSTOP;
  endproperty
  a_alm_code: assert property (p_alm_code)
    else $error("alarm code wrong");
  property p_alm_stop; $rose(alarm_active) |-> motor_speed == 16'h0;
  endproperty
  a_alm_stop: assert property (p_alm_stop)
    else $error("alarm before stop");
endmodule
bind drv_top drv_top_props i_drv_top_props (.mclk(mclk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .motor_fwd(motor_fwd), .motor_rev(motor_rev),
  .motor_speed(motor_speed), .alarm_active(alarm_active),
  .alarm_code(alarm_code));
`default_nettype wire

// File: testbench/drv_term_model.sv
// external switches on the terminal pins and an output-valid timer
// assumes pin requests from the bench, levels held between changes
`timescale 1ns/1ps
`default_nettype none
module drv_term_model import drv_pkg::*; #(
  parameter int MASK_CYC = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [N_TERM-1:0] pin_req,
  output logic [N_TERM-1:0] term_in,
  output logic outs_valid
);
  int mask_cnt;
  always_ff @(posedge mclk) term_in <= pin_req;
  // outputs ignored for a while after power-up
  always_ff @(posedge mclk) begin
    if (!rst_b) mask_cnt <= 0;
    else if (mask_cnt < MASK_CYC) mask_cnt <= mask_cnt + 1;
  end
  assign outs_valid = (mask_cnt >= MASK_CYC);
endmodule
`default_nettype wire

// File: testbench/drv_top_tb_top.sv
// self-checking bench of drv_top over APB and terminal pins
// assumes drv_pkg map and the bind in drv_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module drv_top_tb_top import drv_pkg::*;;
  logic mclk, rst_b, psel, penable, pwrite, pslverr, pready, irq, ov;
  logic [7:0] paddr, alarm_code;
  logic [31:0] pwdata, prdata, q;
  logic [N_TERM-1:0] pin_req, term_in;
  logic t1, t2, t3, r1, r2, forward_run, reverse_run, set2, alm, e;
  logic [15:0] spd;
  logic [3:0] w;
  int mismatches, checked, cyc, seed, i, n;
  drv_term_model i_drv_term_model (.mclk(mclk), .rst_b(rst_b),
    .pin_req(pin_req), .term_in(term_in), .outs_valid(ov));
  drv_top i_drv_top (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_in(term_in), .transistor_out_one(t1), .transistor_out_two(t2),
    .transistor_out_three(t3), .relay_out_general(r1),
    .alarm_relay_out(r2), .motor_fwd(forward_run), .motor_rev(reverse_run),
    .motor_speed(spd), .accel_set_two(set2), .alarm_active(alm),
    .alarm_code(alarm_code), .irq(irq));
  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [1:0] exp_dir(logic [3:0] c, logic sw);
    logic f, r;
    f = sw ? c[COMM_SECOND_FORWARD_RUN] : c[COMM_FWD];
    r = sw ? c[COMM_SECOND_REVERSE_RUN] : c[COMM_REV];
    return (f && r) ? 2'b00 : {f, r};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wait_dir(input logic [1:0] x);
    int k;
    k = 0;
    while (({forward_run, reverse_run} !== x || spd == 16'h0 && x != 0) && k < 3000) begin
      @(posedge mclk);
      k++;
    end
    chk({forward_run, reverse_run}, x);
  endtask
  task automatic pins(input int b, input logic v);
    @(posedge mclk);
    pin_req[b] <= v;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    seed = 14563;
    {psel, penable, pwrite, paddr, pwdata, pin_req, rst_b} = '0;
    repeat (8) @(posedge mclk);
    rst_b <= 1;
    while (ov !== 1'b1) @(posedge mclk);
    apb(0, ADDR_TIME0, 0);
    chk(q, {16'h0, RST_TIME});
    apb(0, ADDR_OUT0 + 8'h10, 0);
    chk(q, {21'h0, RST_OUT_CODE});
    apb(0, 8'h5c, 0);
    chk({31'h0, e}, 1);
    chk({set2, r2}, 0);
    for (i = 0; i < N_TIME; i++) apb(1, ADDR_TIME0 + 8'(4 * i), 0);
    apb(1, ADDR_OUT0, 0);
    apb(1, ADDR_OUT0 + 8'h4, 32'd1000);
    $display("reset values done");
    for (i = 0; i < 12; i++) begin
      w = (i == 5) ? 4'h3 : (i == 11) ? 4'hc : 4'($random(seed));
      if (i == 6) begin
        apb(1, ADDR_TERM0, 32'd87);
        pins(0, 1);
      end
      apb(1, ADDR_COMM, {28'h0, w});
      wait_dir(exp_dir(w, i > 5));
    end
    apb(1, ADDR_COMM, 0);
    wait_dir(0);
    $display("link command word done");
    apb(1, ADDR_TERM0 + 8'h4, 32'd24);
    apb(1, ADDR_TERM0 + 8'hc, 32'd88);
    apb(1, ADDR_TERM0 + 8'h10, 32'd89);
    for (i = 3; i < 5; i++) begin
      pins(i, 1);
      wait_dir(i == 3 ? 2'b10 : 2'b01);
      pins(i, 0);
      wait_dir(0);
    end
    pins(0, 0);
    apb(1, ADDR_TERM0 + 8'h8, 32'd98);
    apb(1, ADDR_TERM0 + 8'h14, 32'd98);
    apb(1, ADDR_TERM0 + 8'h18, 32'd99);
    pins(2, 1);
    repeat (20) @(posedge mclk);
    chk({forward_run, reverse_run, t1, t2}, 4'b0001);
    pins(5, 1);
    wait_dir(2'b10);
    chk({t1, t2}, 2'b10);
    pins(5, 0);
    wait_dir(0);
    pins(6, 1);
    wait_dir(2'b01);
    pins(6, 0);
    wait_dir(0);
    $display("terminal run done");
    apb(1, ADDR_TERM0 + 8'h8, 32'd4);
    repeat (5) @(posedge mclk);
    chk(set2, 1);
    apb(1, ADDR_TERM0 + 8'h8, 32'd1004);
    repeat (5) @(posedge mclk);
    chk(set2, 0);
    $display("time select done");
    apb(1, ADDR_TERM0 + 8'h8, 32'd30);
    apb(1, ADDR_IRQ_EN, 1);
    pins(5, 1);
    wait_dir(2'b10);
    chk({r2, irq}, 0);
    pins(2, 0);
    n = 0;
    while (alm !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    chk({alm, alarm_code, spd, irq, r2}, {1'b1, ALARM_CODE_FSTOP, 18'h3});
    chk({t3, r1}, 2'b11);
    apb(1, ADDR_OUT0 + 8'h10, 32'd1099);
    repeat (3) @(posedge mclk);
    chk(r2, 0);
    apb(1, ADDR_IRQ_CLR, 1);
    @(posedge mclk);
    chk(irq, 0);
    $display("forced stop done");
    report_and_stop();
  end
endmodule
`default_nettype wire
